// [taq_pkg.sv]
// taq_pkg: shared constants and carrier types for the tone access qualifier
// assumes a single 10 MHz system clock and the plain register port
package taq_pkg;

  // register offsets, byte addresses on the plain port
  localparam logic [7:0] TAQ_OFF_POLARITY  = 8'h00; // tone input sense bits
  localparam logic [7:0] TAQ_OFF_STATUS    = 8'h04; // qualified levels
  localparam logic [7:0] TAQ_OFF_SPARE_CMD = 8'h08; // spare audio on/off
  localparam logic [7:0] TAQ_OFF_SPARE_TMO = 8'h0C; // timeout in seconds
  localparam logic [7:0] TAQ_OFF_GROUP0    = 8'h10; // remote output group 0
  localparam logic [7:0] TAQ_OFF_GROUP1    = 8'h14; // remote output group 1
  localparam logic [7:0] TAQ_OFF_CTRL      = 8'h18; // retransmit, mic
  localparam logic [7:0] TAQ_OFF_SERIAL    = 8'h1C; // serial frame / busy

  // polarity field positions
  localparam int TAQ_POL_MAIN_BIT = 0;  // main tone input sense
  localparam int TAQ_POL_USER_BIT = 1;  // user-only tone input sense
  // control field positions
  localparam int TAQ_CTL_RETX_BIT = 0;  // retransmit control receiver
  localparam int TAQ_CTL_MIC_BIT  = 1;  // local mic active
  // spare command field positions
  localparam int TAQ_SPR_ON_BIT   = 0;  // start spare audio
  localparam int TAQ_SPR_HANG_BIT = 1;  // user hangup

  // command codes that program the tone input senses
  localparam logic [15:0] TAQ_CODE_MAIN_POL = 16'h5104;
  localparam logic [15:0] TAQ_CODE_USER_POL = 16'h5112;

  // reset values
  localparam logic [1:0] TAQ_POL_RST     = 2'h3;  // both active high
  localparam logic [7:0] TAQ_TMO_RST     = 8'h3C; // 60 s spare timeout
  localparam logic [1:0] TAQ_CTL_RST     = 2'h0;

  // timing: one second tick at the 10 MHz clock
  localparam int TAQ_CLK_HZ       = 10_000_000;
  localparam int TAQ_TICK_MS      = 1000;
  localparam int TAQ_TICK_CYCLES  = TAQ_CLK_HZ / 1000 * TAQ_TICK_MS;
  // serial frame shape
  localparam int TAQ_FRAME_BITS   = 24;
  localparam int TAQ_BIT_CYCLES   = 100;       // 100 kbit/s serial rate

  // decoder access owner
  typedef enum logic [3:0]
  {
    TAQ_SRC_NONE = 4'h1,
    TAQ_SRC_MIC  = 4'h2,
    TAQ_SRC_CTRL = 4'h4,
    TAQ_SRC_RPT  = 4'h8
  } taq_src_t;

  // serial shifter states
  typedef enum logic [2:0]
  {
    TAQ_SH_IDLE = 3'h1,
    TAQ_SH_BIT  = 3'h2,
    TAQ_SH_DONE = 3'h4
  } taq_sh_t;

  // qualified access levels
  typedef struct packed
  {
    logic repeater_access;  // may use the repeater
    logic user_level;       // user commands allowed
    logic operator_level;   // control operator functions allowed
  } taq_access_t;

  // synchronised raw pin levels
  typedef struct packed
  {
    logic tone_main;
    logic tone_user;
    logic carrier;
    logic busy;
  } taq_pins_t;

endpackage : taq_pkg

// [taq_tone_access_qualifier.sv]
// taq_tone_access_qualifier: tone access gating, decoder priority, spare
// audio keying, remote output groups and remote-base serial stream
// assumes pins are asynchronous, register port is on clk, reset synchronous
// Summary of operation
// (R1) main tone qualifies all gated activities
// (R2) user tone qualifies user commands only
// (R3) each tone input has programmable sense
// (R4) codes 5104/5112 set sense; 1=high
// (R5) switch 3 sets carrier detect sense
// (R6) installer sets switch 3 ON without receiver
// (R7) control receiver gets decoder after mic
// (R8) owner maps channel 4 for control receiver
// (R9) retransmit control receiver only if selected
// (R10) spare command keys tx, routes spare audio
// (R11) user hangup ends spare audio
// (R12) programmable timeout ends spare audio
// (R13) owner maps channel 3 for spare audio; decoder_owner has no spare audio code, spare_audio_route alone carries it
// (R14) two 8-bit groups, whole-group updates
// (R15) five bits select tone, sixth enables
// (R16) serial stream carries stored tone bits
// (R17) serial stream carries voice recorder control
// (R18) voice recorder reports on busy input
// (R19) two-stage sync before polarity applied
module taq_tone_access_qualifier
#(
  parameter int TICK_CYCLES = taq_pkg::TAQ_TICK_CYCLES // long count
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // asynchronous pins
  input  wire logic        sub_audible_tone_present_main,
  input  wire logic        sub_audible_tone_present_user,
  input  wire logic        carrier_detect_input,
  input  wire logic        voice_recorder_busy,
  input  wire logic        config_switch3_on,
  // decoder requests
  input  wire logic        repeater_rx_active,
  // outputs
  output taq_pkg::taq_access_t access,
  output taq_pkg::taq_src_t    decoder_owner,
  output logic             ctrl_rx_retransmit,
  output logic             tx_key,
  output logic             spare_audio_route,
  output logic      [7:0]  group0_out,
  output logic      [7:0]  group1_out,
  output logic             serial_data,
  output logic             serial_clk,
  output logic             serial_latch
);

  // elaboration checks: a tick needs at least one cycle, and the bit
  // divider is seven bits wide, so a longer bit time would wrap it
  if (TICK_CYCLES < 1)
  begin : g_tick_check
    $error("TICK_CYCLES must be at least one");
  end
  if (taq_pkg::TAQ_BIT_CYCLES > 128 || taq_pkg::TAQ_BIT_CYCLES < 2)
  begin : g_bit_check
    $error("bit time must be 2 to 128 cycles");
  end

  // two-stage synchronisers, first stage read only by the second
  taq_pkg::taq_pins_t pins_meta_q;   // first stage
  taq_pkg::taq_pins_t pins_q;        // second stage, safe to read
  logic               sw3_meta_q;    // switch first stage
  logic               sw3_q;         // switch second stage

  // synchronise every asynchronous pin before any logic looks at it
  always_ff @(posedge clk)
  begin
    pins_meta_q <= '{sub_audible_tone_present_main,
                     sub_audible_tone_present_user,
                     carrier_detect_input,
                     voice_recorder_busy};       // R19
    pins_q      <= pins_meta_q;                  // R19
    sw3_meta_q  <= config_switch3_on;
    sw3_q       <= sw3_meta_q;
  end

  // software state
  logic [1:0]  pol_q;      // tone senses, 1 = active high
  logic [1:0]  ctl_q;      // retransmit and mic bits
  logic [7:0]  tmo_q;      // spare timeout, seconds, zero disables
  logic [7:0]  grp0_q;     // remote output group 0
  logic [7:0]  grp1_q;     // remote output group 1
  logic [23:0] frame_q;    // pending serial frame
  logic        send_q;     // frame waiting to go

  // write decode
  // a strobe at an unmapped address decodes to nothing and is dropped
  wire w_pol   = wr && (addr == taq_pkg::TAQ_OFF_POLARITY);
  wire w_spare = wr && (addr == taq_pkg::TAQ_OFF_SPARE_CMD);
  wire w_tmo   = wr && (addr == taq_pkg::TAQ_OFF_SPARE_TMO);
  wire w_grp0  = wr && (addr == taq_pkg::TAQ_OFF_GROUP0);
  wire w_grp1  = wr && (addr == taq_pkg::TAQ_OFF_GROUP1);
  wire w_ctl   = wr && (addr == taq_pkg::TAQ_OFF_CTRL);
  wire w_ser   = wr && (addr == taq_pkg::TAQ_OFF_SERIAL);

  // sense command: code in [31:16], sense bit in [0]
  wire [15:0] pol_code = wdata[31:16];
  wire        pol_main = w_pol && (pol_code == taq_pkg::TAQ_CODE_MAIN_POL);
  wire        pol_user = w_pol && (pol_code == taq_pkg::TAQ_CODE_USER_POL);

  // polarity register, only the two known codes take effect
  always_ff @(posedge clk)
  begin
    if (rst)
      pol_q <= taq_pkg::TAQ_POL_RST;
    else
    begin
      if (pol_main)                                      // R4
        pol_q[taq_pkg::TAQ_POL_MAIN_BIT] <= wdata[0];    // R3
      if (pol_user)                                      // R4
        pol_q[taq_pkg::TAQ_POL_USER_BIT] <= wdata[0];    // R3
    end
  end

  // plain control registers; groups load all eight bits in one write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctl_q  <= taq_pkg::TAQ_CTL_RST;
      tmo_q  <= taq_pkg::TAQ_TMO_RST;
      grp0_q <= 8'h00;
      grp1_q <= 8'h00;
    end
    else
    begin
      if (w_ctl)
        ctl_q <= wdata[1:0];
      if (w_tmo)
        tmo_q <= wdata[7:0];
      if (w_grp0)
        grp0_q <= wdata[7:0];      // R14 R15
      if (w_grp1)
        grp1_q <= wdata[7:0];      // R14
    end
  end

  // apply senses after synchronisation
  wire tone_main = ~(pins_q.tone_main ^ pol_q[taq_pkg::TAQ_POL_MAIN_BIT]);
  wire tone_user = ~(pins_q.tone_user ^ pol_q[taq_pkg::TAQ_POL_USER_BIT]);
  // switch on means active high; an absent receiver reads idle low
  wire carrier   = ~(pins_q.carrier ^ sw3_q);            // R5 R6

  // access levels: main tone qualifies all, user tone only user level
  assign access.repeater_access = tone_main;             // R1
  assign access.operator_level  = tone_main;             // R1 R2
  assign access.user_level      = tone_main | tone_user; // R1 R2

  // decoder priority: mic, then control receiver, then repeater input
  // a repeater request only wins while neither higher source is active
  wire mic_on = ctl_q[taq_pkg::TAQ_CTL_MIC_BIT];
  assign decoder_owner = mic_on             ? taq_pkg::TAQ_SRC_MIC  :
                         carrier            ? taq_pkg::TAQ_SRC_CTRL : // R7
                         repeater_rx_active ? taq_pkg::TAQ_SRC_RPT  :
                                              taq_pkg::TAQ_SRC_NONE;

  // retransmit only when the operator option is set and carrier is up
  assign ctrl_rx_retransmit = carrier &&
                              ctl_q[taq_pkg::TAQ_CTL_RETX_BIT];      // R9

  // spare audio session with one-second ticks for the timeout
  logic                     spare_q;   // spare audio active
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_q; // sub-second counter
  logic [7:0]               secs_q;    // seconds on
  wire tick_done = (tick_q == ($bits(tick_q))'(TICK_CYCLES - 1));
  wire spare_on  = w_spare && wdata[taq_pkg::TAQ_SPR_ON_BIT];
  wire hangup    = w_spare && wdata[taq_pkg::TAQ_SPR_HANG_BIT];
  wire timed_out = (tmo_q != 8'h00) && (secs_q >= tmo_q);

  // hangup and timeout win over a start in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      spare_q <= 1'b0;
      tick_q  <= '0;
      secs_q  <= 8'h00;
    end
    else if (hangup || (spare_q && timed_out))
    begin
      spare_q <= 1'b0;                 // R11 R12
      tick_q  <= '0;
      secs_q  <= 8'h00;
    end
    // a start while already on leaves the running count alone
    else if (spare_on && !spare_q)
    begin
      spare_q <= 1'b1;                 // R10
      tick_q  <= '0;
      secs_q  <= 8'h00;
    end
    else if (spare_q)
    begin
      // count seconds while active, saturating
      tick_q <= tick_done ? '0 : tick_q + 1'b1;
      if (tick_done && secs_q != 8'hFF)
        secs_q <= secs_q + 8'h01;      // R12
    end
  end

  assign tx_key            = spare_q || ctrl_rx_retransmit; // R10
  assign spare_audio_route = spare_q;                       // R10
  assign group0_out        = grp0_q;
  assign group1_out        = grp1_q;

  // serial frame: [23:16] tone bits, [15:8] recorder control, [7:0] data
  // a write while a frame is shifting is ignored; poll busy first
  taq_pkg::taq_sh_t         sh_q;      // shifter state
  logic [4:0]               bit_q;     // bits left after the current one
  logic [6:0]               div_q;     // bit-time divider
  logic [23:0]              shreg_q;   // shifting data
  wire div_end = (div_q == 7'(taq_pkg::TAQ_BIT_CYCLES - 1));
  wire sh_busy = (sh_q != taq_pkg::TAQ_SH_IDLE);

  // frame capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_q <= 24'h000000;
      send_q  <= 1'b0;
    end
    else if (w_ser && !sh_busy && !send_q)
    begin
      frame_q <= wdata[23:0];          // R16 R17
      send_q  <= 1'b1;
    end
    // the idle shifter takes the frame on this edge, so the request drops
    else if (sh_q == taq_pkg::TAQ_SH_IDLE)
      send_q  <= 1'b0;
  end

  // msb-first shifter, one bit per bit time, latch pulse at the end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sh_q    <= taq_pkg::TAQ_SH_IDLE;
      bit_q   <= 5'h00;
      div_q   <= 7'h00;
      shreg_q <= 24'h000000;
    end
    else
    begin
      case (sh_q)
        taq_pkg::TAQ_SH_IDLE:
        begin
          div_q <= 7'h00;
          if (send_q)
          begin
            shreg_q <= frame_q;        // R16 R17
            bit_q   <= 5'(taq_pkg::TAQ_FRAME_BITS - 1);
            sh_q    <= taq_pkg::TAQ_SH_BIT;
          end
        end
        taq_pkg::TAQ_SH_BIT:
        begin
          div_q <= div_end ? 7'h00 : div_q + 7'h01;
          if (div_end)
          begin
            shreg_q <= {shreg_q[22:0], 1'b0};
            if (bit_q == 5'h00)
              sh_q <= taq_pkg::TAQ_SH_DONE;
            else
              bit_q <= bit_q - 5'h01;
          end
        end
        taq_pkg::TAQ_SH_DONE:
          sh_q <= taq_pkg::TAQ_SH_IDLE;
        default:
          sh_q <= taq_pkg::TAQ_SH_IDLE;
      endcase
    end
  end

  // link clock and latch leave through flip-flops so that a one-hot state
  // change can never glitch them; each flop is loaded with what the state
  // will show after this edge, so neither lags the data by a cycle
  logic serial_clk_q;    // clock pin, high in the second half of a bit
  logic serial_latch_q;  // latch pin, one cycle after the last bit
  wire  sh_in_bit      = (sh_q == taq_pkg::TAQ_SH_BIT);
  wire  serial_clk_d   = sh_in_bit && !div_end &&
                         (div_q >= 7'(taq_pkg::TAQ_BIT_CYCLES / 2 - 1));
  wire  serial_latch_d = sh_in_bit && div_end && (bit_q == 5'h00);

  // output flops for the link strobes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_clk_q   <= 1'b0;
      serial_latch_q <= 1'b0;
    end
    else
    begin
      serial_clk_q   <= serial_clk_d;   // R16 R17
      serial_latch_q <= serial_latch_d; // R17
    end
  end

  assign serial_data  = shreg_q[23];
  assign serial_clk   = serial_clk_q;
  assign serial_latch = serial_latch_q;

  // read mux, one cycle later; unmapped reads zero
  logic [31:0] rmux;
  always_comb
  begin
    case (addr)
      taq_pkg::TAQ_OFF_POLARITY:  rmux = {30'h0, pol_q};
      taq_pkg::TAQ_OFF_STATUS:    rmux = {24'h0, pins_q.busy, carrier,
                                          tone_user, tone_main, 1'b0,
                                          access};       // R18
      taq_pkg::TAQ_OFF_SPARE_CMD: rmux = {24'h0, secs_q[6:0], spare_q};
      taq_pkg::TAQ_OFF_SPARE_TMO: rmux = {24'h0, tmo_q};
      taq_pkg::TAQ_OFF_GROUP0:    rmux = {24'h0, grp0_q};
      taq_pkg::TAQ_OFF_GROUP1:    rmux = {24'h0, grp1_q};
      taq_pkg::TAQ_OFF_CTRL:      rmux = {30'h0, ctl_q};
      taq_pkg::TAQ_OFF_SERIAL:    rmux = {6'h0, pins_q.busy,
                                          sh_busy | send_q, frame_q};
      default:                    rmux = 32'h0;
    endcase
  end

  // read data register; zero outside the answer cycle, so a stale word
  // left on the bus can never be taken for a fresh read
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 32'h0;
    else
      rdata <= rd ? rmux : 32'h0;
  end

endmodule // taq_tone_access_qualifier

// [taq_checker_properties.sv]
// taq_checker_properties: port-level assertions for the tone access block
// assumes a bind to the top module; one clock, synchronous reset
module taq_checker_properties (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic [7:0]           addr,
  input wire logic [31:0]          wdata,
  input wire logic                 wr,
  input wire logic                 sub_audible_tone_present_main,
  input wire logic                 sub_audible_tone_present_user,
  input wire logic                 carrier_detect_input,
  input wire logic                 config_switch3_on,
  input wire taq_pkg::taq_access_t access,
  input wire taq_pkg::taq_src_t    decoder_owner,
  input wire logic                 ctrl_rx_retransmit,
  input wire logic                 tx_key,
  input wire logic                 spare_audio_route,
  input wire logic [7:0]           group0_out
);
  logic [1:0] pol_q;  // mirror of both tone senses
  logic [1:0] ctl_q;  // mirror of mic and retransmit bits
  logic [1:0] age_q;  // edges since reset, saturating
  // mirrors follow only the writes the block should accept
  wire       pw    = wr && addr == taq_pkg::TAQ_OFF_POLARITY;
  wire       pm    = pw && wdata[31:16] == taq_pkg::TAQ_CODE_MAIN_POL;
  wire       pu    = pw && wdata[31:16] == taq_pkg::TAQ_CODE_USER_POL;
  wire [1:0] pol_d = {pu ? wdata[0] : pol_q[1], pm ? wdata[0] : pol_q[0]};
  wire       cw    = wr && addr == taq_pkg::TAQ_OFF_CTRL;
  wire [1:0] ctl_d = cw ? wdata[1:0] : ctl_q;
  wire [1:0] age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
  // age guards against sync stages still holding reset values
  always_ff @(posedge clk)
  begin
    pol_q <= rst ? taq_pkg::TAQ_POL_RST : pol_d;
    ctl_q <= rst ? taq_pkg::TAQ_CTL_RST : ctl_d;
    age_q <= rst ? 2'h0 : age_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // pins and senses quiet long enough to pass the sync stages
  sequence s_tones_settled;
    $stable({sub_audible_tone_present_main, sub_audible_tone_present_user,
             pol_q})[*3] ##0 age_q == 2'h3;
  endsequence
  sequence s_carrier_settled;
    $stable({carrier_detect_input, config_switch3_on, ctl_q[0]})[*3]
      ##0 age_q == 2'h3;
  endsequence
  sequence s_spare_start;
    wr && addr == taq_pkg::TAQ_OFF_SPARE_CMD && wdata[1:0] == 2'h1;
  endsequence
  a_oper_needs_main: assert property (
    access.operator_level == access.repeater_access) else $error("oper");
  a_oper_has_user: assert property (
    access.operator_level |-> access.user_level) else $error("user");
  a_main_sense: assert property (s_tones_settled |->
    access.repeater_access == (sub_audible_tone_present_main == pol_q[0]))
    else $error("main sense");
  a_user_sense: assert property (s_tones_settled |->
    access.user_level == (access.repeater_access ||
    sub_audible_tone_present_user == pol_q[1])) else $error("user sense");
  a_carrier_sense: assert property (s_carrier_settled ##0 ctl_q[0] |->
    ctrl_rx_retransmit == (carrier_detect_input == config_switch3_on))
    else $error("carrier sense");
  a_retx_selected: assert property (
    ctrl_rx_retransmit |-> ctl_q[0] && tx_key) else $error("retx");
  a_mic_first: assert property (
    ctl_q[1] |-> decoder_owner == taq_pkg::TAQ_SRC_MIC) else $error("mic");
  a_ctrl_second: assert property (ctrl_rx_retransmit && !ctl_q[1] |->
    decoder_owner == taq_pkg::TAQ_SRC_CTRL) else $error("ctrl prio");
  a_spare_keys_tx: assert property (
    s_spare_start |=> spare_audio_route && tx_key) else $error("spare");
  a_hangup_ends: assert property (wr && wdata[1] &&
    addr == taq_pkg::TAQ_OFF_SPARE_CMD |=> !spare_audio_route)
    else $error("hangup");
  a_group_whole: assert property (wr && addr == taq_pkg::TAQ_OFF_GROUP0
    |=> group0_out == $past(wdata[7:0])) else $error("group");
endmodule // taq_checker_properties

bind taq_tone_access_qualifier taq_checker_properties chk_u (
  .clk, .rst, .addr, .wdata, .wr, .sub_audible_tone_present_main,
  .sub_audible_tone_present_user, .carrier_detect_input,
  .config_switch3_on, .access, .decoder_owner, .ctrl_rx_retransmit,
  .tx_key, .spare_audio_route, .group0_out);

// [taq_far_side.sv]
// taq_far_side: tone decoders, control receiver and voice recorder model
// assumes the bench sets pin levels; absent sources sit at the pull-down
module taq_far_side (
  input  wire logic        clk,
  input  wire logic [2:0]  lvl,
  input  wire logic        serial_data,
  input  wire logic        serial_clk,
  input  wire logic        serial_latch,
  output logic      [23:0] frame,
  output wire logic        sub_audible_tone_present_main,
  output wire logic        sub_audible_tone_present_user,
  output wire logic        carrier_detect_input,
  output wire logic        voice_recorder_busy
);
  logic [23:0] shift_q;  // bits gathered on the serial clock
  logic [5:0]  busy_q;   // recorder busy countdown after a frame
  initial busy_q = 6'h00;
  // decoder and receiver levels; unplugged carrier reads low
  assign sub_audible_tone_present_main = lvl[2];
  assign sub_audible_tone_present_user = lvl[1];
  assign carrier_detect_input          = lvl[0];
  // data is steady through the high half of each bit
  always @(posedge serial_clk)
    shift_q <= {shift_q[22:0], serial_data};
  // recorder takes the frame on the latch, then reports busy
  always @(posedge clk)
  begin
    if (serial_latch)
      frame <= shift_q;
    busy_q <= serial_latch ? 6'h32 : (busy_q == 6'h0) ? 6'h0 : busy_q - 6'h1;
  end
  assign voice_recorder_busy = busy_q != 6'h00;
endmodule // taq_far_side

// [tb_tone_access_qualifier.sv]
// tb_tone_access_qualifier: register-level tests of the tone access block
// assumes the far-side model and the bound checker are compiled with it
module tb_tone_access_qualifier;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk, rst, wr, rd, m, u, car;
  logic                 config_switch3_on, repeater_rx_active;
  logic [7:0]           addr, group0_out, group1_out;
  logic [31:0]          wdata, rdata;
  logic [2:0]           lvl;    // main tone, user tone, carrier
  logic [23:0]          frame;  // last frame the recorder took
  logic                 ctrl_rx_retransmit, tx_key, spare_audio_route;
  logic                 serial_data, serial_clk, serial_latch;
  wire                  sub_audible_tone_present_main;
  wire                  sub_audible_tone_present_user;
  wire                  carrier_detect_input, voice_recorder_busy;
  taq_pkg::taq_access_t access;
  taq_pkg::taq_src_t    decoder_owner;
  int                   errors, total_checks, k;
  // short tick so the spare timeout runs out in tens of cycles
  taq_tone_access_qualifier #(.TICK_CYCLES(10)) dut_u (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .sub_audible_tone_present_main, .sub_audible_tone_present_user,
    .carrier_detect_input, .voice_recorder_busy, .config_switch3_on,
    .repeater_rx_active, .access, .decoder_owner, .ctrl_rx_retransmit,
    .tx_key, .spare_audio_route, .group0_out, .group1_out, .serial_data,
    .serial_clk, .serial_latch);
  taq_far_side fs_u (
    .clk, .lvl, .serial_data, .serial_clk, .serial_latch, .frame,
    .sub_audible_tone_present_main, .sub_audible_tone_present_user,
    .carrier_detect_input, .voice_recorder_busy);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one-cycle strobes; outputs looked at on the falling edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk,
                        input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & msk, e);
  endtask
  task automatic summarize;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the whole run needs well under 8000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
  initial
  begin
    {rst, wr, rd, config_switch3_on, repeater_rx_active} = 5'h10;
    addr = 8'h00;
    wdata = 32'h0;
    lvl = 3'h0;
    errors = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(taq_pkg::TAQ_OFF_POLARITY, 32'hFF, 32'h3);
    rd_chk(taq_pkg::TAQ_OFF_SPARE_TMO, 32'hFF, 32'h3C);
    // every sense pair against every tone level pair; bad code ignored
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(8'h00, {taq_pkg::TAQ_CODE_MAIN_POL, 15'h0, i[0]});
      wr_reg(8'h00, {taq_pkg::TAQ_CODE_USER_POL, 15'h0, i[1]});
      wr_reg(8'h00, {16'h5105, 15'h0, ~i[0]});
      @(posedge clk);
      lvl[2:1] <= {i[2], i[3]};
      repeat (4) @(posedge clk);
      m = i[2] == i[0];
      u = i[3] == i[1];
      rd_chk(8'h04, 32'h7, {29'h0, m, m | u, m});
    end
    // switch sense, retransmit choice and decoder priority
    for (int j = 0; j < 16; j++)
    begin
      @(posedge clk);
      repeater_rx_active <= 1'b1;
      config_switch3_on <= j[0];
      lvl[0] <= j[1];
      wr_reg(taq_pkg::TAQ_OFF_CTRL, {30'h0, j[3], j[2]});
      repeat (4) @(negedge clk);
      car = j[1] == j[0];
      chk(32'({ctrl_rx_retransmit, tx_key}), {30'h0, {2{car & j[2]}}});
      chk(32'(decoder_owner), 32'(j[3] ? taq_pkg::TAQ_SRC_MIC : car ?
        taq_pkg::TAQ_SRC_CTRL : taq_pkg::TAQ_SRC_RPT));
    end
    // no receiver: switch on and a low pin leave the decoder free
    @(posedge clk);
    lvl[0] <= 1'b0;
    wr_reg(taq_pkg::TAQ_OFF_CTRL, 32'h0);
    chk(32'(decoder_owner), 32'(taq_pkg::TAQ_SRC_RPT));
    wr_reg(taq_pkg::TAQ_OFF_SPARE_TMO, 32'h3);
    wr_reg(taq_pkg::TAQ_OFF_SPARE_CMD, 32'h3);
    chk(32'(spare_audio_route), 32'h0);
    wr_reg(taq_pkg::TAQ_OFF_SPARE_CMD, 32'h1);
    chk(32'({tx_key, spare_audio_route}), 32'h3);
    repeat (15) @(negedge clk);
    chk(32'(spare_audio_route), 32'h1);
    repeat (35) @(negedge clk);
    chk(32'({tx_key, spare_audio_route}), 32'h0);
    wr_reg(taq_pkg::TAQ_OFF_SPARE_CMD, 32'h1);
    wr_reg(taq_pkg::TAQ_OFF_SPARE_CMD, 32'h2);
    chk(32'(spare_audio_route), 32'h0);
    // five tone select bits plus enable in one group write
    wr_reg(taq_pkg::TAQ_OFF_GROUP0, 32'h3F);
    wr_reg(taq_pkg::TAQ_OFF_GROUP1, 32'hA5);
    chk(32'({group1_out, group0_out}), 32'hA53F);
    // frame of tone bits, recorder control, data; a second is refused
    wr_reg(taq_pkg::TAQ_OFF_SERIAL, 32'h1F825A);
    rd_chk(taq_pkg::TAQ_OFF_SERIAL, 32'h1000000, 32'h1000000);
    wr_reg(taq_pkg::TAQ_OFF_SERIAL, 32'h0);
    k = 0;
    while (serial_latch !== 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    chk({8'h0, frame}, 32'h1F825A);
    repeat (4) @(posedge clk);
    rd_chk(taq_pkg::TAQ_OFF_SERIAL, 32'h3000000, 32'h2000000);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
    summarize();
  end
endmodule // tb_tone_access_qualifier
